// ==== rtl/fmr_pkg.sv ====
package fmr_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_DEMOD_CONTROL  = 16'hfe40;
  localparam logic [15:0] IDX_ADC_FILTER_CFG = 16'hfe41;
  localparam logic [15:0] IDX_PILOT_LOW      = 16'hfe42;
  localparam logic [15:0] IDX_PILOT_HIGH     = 16'hfe43;
  localparam logic [15:0] IDX_CARRIER_LOW    = 16'hfe44;
  localparam logic [15:0] IDX_CARRIER_HIGH   = 16'hfe45;
  localparam logic [15:0] IDX_LEFT_LOW       = 16'hfe4e;
  localparam logic [15:0] IDX_LEFT_HIGH      = 16'hfe4f;
  localparam logic [15:0] IDX_RIGHT_LOW      = 16'hfe50;
  localparam logic [15:0] IDX_RIGHT_HIGH     = 16'hfe51;
  localparam logic [15:0] IDX_BLOCK_DATA     = 16'hfe52;
  localparam logic [15:0] IDX_BLOCK_CHECK    = 16'hfe53;
  localparam logic [15:0] IDX_IQ_SCALE       = 16'hfe5b;

  localparam int          ADDR_W     = 18;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // demodulator control word, one field per documented bit
  typedef struct packed {
    logic       rsv_15;
    logic       ext_input_right_enable;
    logic       ext_input_left_enable;
    logic       ext_input_single_enable;
    logic [3:0] rsv_11_8;
    logic       iq_scaling_enable;
    logic       global_sync_enable;
    logic       radio_data_hold_alignment;
    logic       single_channel_select;
    logic       deemphasis_select;
    logic       radio_data_enable;
    logic       auto_fine_tune_enable;
    logic       demodulator_enable;
  } fmr_ctrl_t;

  // divider tables
  localparam logic [5:0] VCO_DIV_36 = 6'h24;
  localparam logic [5:0] VCO_DIV_30 = 6'h1e;
  localparam logic [5:0] VCO_DIV_25 = 6'h19;
  localparam logic [4:0] CH_DIV_16  = 5'h10;
  localparam logic [4:0] CH_DIV_20  = 5'h14;
  localparam logic [4:0] CH_DIV_24  = 5'h18;
  localparam logic [7:0] CCF_BASE   = 8'h10;
  localparam int         CCF_FRAC   = 21;

  // radio data block code
  localparam logic [10:0] BLOCK_POLY  = 11'h5b9;
  localparam logic [9:0]  OFS_A       = 10'h0fc;
  localparam logic [9:0]  OFS_B       = 10'h198;
  localparam logic [9:0]  OFS_C       = 10'h168;
  localparam logic [9:0]  OFS_CP      = 10'h350;
  localparam logic [9:0]  OFS_D       = 10'h1b4;
  localparam logic [4:0]  BLOCK_LAST  = 5'h19;
  localparam int          IQ_SHIFT    = 7;

  // bit clock: rate in tenths of bits per second
  localparam longint CLK_HZ      = 64'd50_000_000;
  localparam longint RATE_X10    = 64'd11875;
  localparam logic [31:0] NCO_INC =
    32'((RATE_X10 << 32) / (CLK_HZ * 64'd10));
  localparam logic [31:0] NCO_NUDGE = 32'h0000_0400;

endpackage

// ==== rtl/fmr_demod_ctrl.sv ====
// Behaviour
// - control bit 6 clear holds demodulators and filters in reset
// - control bit 4 set selects mono, clear selects stereo
// - control bit 3 set selects 75 us de-emphasis, else 50 us
// - radio data decoding runs only while control bit 2 is set
// - bit 5 holds symbol alignment; clear keeps searching for alignment
// - bit 1 clear fixes tuning at the carrier centre registers
// - bit 7 scales I by high byte, Q by low byte
// - bits 14, 13, 12 route AD2, AD1, AD3 to external inputs
// - carrier centre is 27-bit signed, low 16 and high 11
// - vco divider code 00 gives 36, 01/10 give 30, 11 gives 25
// - channel divider code 00 gives 16, 10 gives 20, else 24
// - vco multiplier is 4 times divider plus centre factor
// - 18-bit samples split: bits 17:2 high, 1:0 at 15:14 low
// - each decoded block stores data, checkword and raises request
// - bits are recovered at 1187.5 bits per second
// - block alignment found automatically; errored blocks never corrected
// - check register: checkword 12:3, valid bit 2, index 1:0
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fmr_demod_ctrl
  import fmr_pkg::*;
(
  input  wire logic                aclk,            // 50 MHz clock
  input  wire logic                aresetn,         // sync reset, low
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,    // write address
  input  wire logic                s_axi_awvalid,   // write addr valid
  output logic                     s_axi_awready,   // write addr ready
  input  wire logic [31:0]         s_axi_wdata,     // write data
  input  wire logic [3:0]          s_axi_wstrb,     // byte enables
  input  wire logic                s_axi_wvalid,    // write data valid
  output logic                     s_axi_wready,    // write data ready
  output logic [1:0]               s_axi_bresp,     // write response
  output logic                     s_axi_bvalid,    // response valid
  input  wire logic                s_axi_bready,    // response ready
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,    // read address
  input  wire logic                s_axi_arvalid,   // read addr valid
  output logic                     s_axi_arready,   // read addr ready
  output logic [31:0]              s_axi_rdata,     // read data
  output logic [1:0]               s_axi_rresp,     // read response
  output logic                     s_axi_rvalid,    // read data valid
  input  wire logic                s_axi_rready,    // read data ready
  input  wire logic [1:0]          vco_divider_select,     // vco code
  input  wire logic [1:0]          channel_divider_select, // fm code
  input  wire logic signed [26:0]  fine_tune_offset, // loop correction
  input  wire logic signed [15:0]  i_in,            // raw I sample
  input  wire logic signed [15:0]  q_in,            // raw Q sample
  input  wire logic                sample_strobe,   // new L/R sample
  input  wire logic [17:0]         left_in,         // left sample
  input  wire logic [17:0]         right_in,        // right sample
  input  wire logic                baseband_bit,    // sliced rds level
  output var fmr_ctrl_t            ctrl_ff,         // control fields
  output logic                     filt_reset_ff,   // filters in reset
  output logic [28:0]              pilot_factor_ff, // pilot pll word
  output logic signed [26:0]       tune_word_ff,    // tuning word
  output logic [5:0]               vco_div_ff,      // vco divider
  output logic [4:0]               ch_div_ff,       // channel divider
  output logic signed [29:0]       vco_mult_ff,     // multiplier q21
  output logic signed [15:0]       i_scaled_ff,     // compensated I
  output logic signed [15:0]       q_scaled_ff,     // compensated Q
  output logic                     rds_irq_ff       // block request
);

  // block checkword of a data word, remainder of d * x^10 by the poly
  function automatic logic [9:0] crc10(input logic [15:0] d);
    logic [10:0] r;
    r = 11'h000;
    for (int k = 15; k >= 0; k--)
    begin
      r = {r[9:0], 1'b0} ^ ((r[9] ^ d[k]) ? BLOCK_POLY : 11'h000);
    end
    return r[9:0];
  endfunction

  // merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // offset word expected at each block position
  function automatic logic exp_match(input logic [9:0] syn,
                                     input logic [1:0] blk);
    case (blk)
      2'h0:    return syn == OFS_A;
      2'h1:    return syn == OFS_B;
      2'h2:    return (syn == OFS_C) || (syn == OFS_CP);
      default: return syn == OFS_D;
    endcase
  endfunction

  logic [15:0]        adcf_ff, pll_lo_ff, ccf_lo_ff, phscl_ff;
  logic [12:0]        pll_hi_ff;
  logic [10:0]        ccf_hi_ff;
  logic [17:0]        left_ff, right_ff;
  logic [15:0]        rds_data_ff;
  logic [12:0]        radio_block_check_ff;
  logic               aw_pend_ff, w_pend_ff;
  logic [15:0]        aw_idx_ff;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic [31:0]        nco_ff;
  logic               bit_d_ff, synced_ff;
  logic [4:0]         bitcnt_ff;
  logic [1:0]         blk_ff;
  logic [25:0]        shift_ff;

  // write channel handshakes; address and data may come in either order
  wire aw_hs      = s_axi_awvalid & s_axi_awready;
  wire w_hs       = s_axi_wvalid & s_axi_wready;
  wire do_write   = aw_pend_ff & w_pend_ff & ~s_axi_bvalid;
  wire nxt_aw_pend = aw_pend_ff ? ~do_write : aw_hs;
  wire nxt_w_pend  = w_pend_ff ? ~do_write : w_hs;
  wire nxt_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire ar_hs      = s_axi_arvalid & s_axi_arready;
  wire nxt_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [15:0] ar_idx = s_axi_araddr[ADDR_W-1:2];

  // write decode; read-only words answer with slave error
  wire wr_ctrl  = do_write & (aw_idx_ff == IDX_DEMOD_CONTROL);
  wire wr_adcf  = do_write & (aw_idx_ff == IDX_ADC_FILTER_CFG);
  wire wr_pllo  = do_write & (aw_idx_ff == IDX_PILOT_LOW);
  wire wr_plhi  = do_write & (aw_idx_ff == IDX_PILOT_HIGH);
  wire wr_cclo  = do_write & (aw_idx_ff == IDX_CARRIER_LOW);
  wire wr_cchi  = do_write & (aw_idx_ff == IDX_CARRIER_HIGH);
  wire wr_phs   = do_write & (aw_idx_ff == IDX_IQ_SCALE);
  wire wr_ok    = wr_ctrl | wr_adcf | wr_pllo | wr_plhi | wr_cclo
                | wr_cchi | wr_phs;
  wire [15:0] cur_hi  = {3'h0, pll_hi_ff};
  // narrow registers merge at full width, then keep their own bits
  wire [15:0] plhi_word = merge16(cur_hi, wdata_ff, wstrb_ff);
  wire [15:0] cchi_word = merge16({5'h00, ccf_hi_ff}, wdata_ff, wstrb_ff);

  // read mux; unmapped addresses decode error with zero data
  logic [15:0] rd_word;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_DEMOD_CONTROL:  rd_word = ctrl_ff;
      IDX_ADC_FILTER_CFG: rd_word = adcf_ff;
      IDX_PILOT_LOW:      rd_word = pll_lo_ff;
      IDX_PILOT_HIGH:     rd_word = cur_hi;
      IDX_CARRIER_LOW:    rd_word = ccf_lo_ff;
      IDX_CARRIER_HIGH:   rd_word = {5'h00, ccf_hi_ff};
      IDX_LEFT_LOW:       rd_word = {left_ff[1:0], 14'h0000};
      IDX_LEFT_HIGH:      rd_word = left_ff[17:2];
      IDX_RIGHT_LOW:      rd_word = {right_ff[1:0], 14'h0000};
      IDX_RIGHT_HIGH:     rd_word = right_ff[17:2];
      IDX_BLOCK_DATA:     rd_word = rds_data_ff;
      IDX_BLOCK_CHECK:    rd_word = {3'h0, radio_block_check_ff};
      IDX_IQ_SCALE:       rd_word = phscl_ff;
      default:
      begin
        rd_word = 16'h0000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // bus slave state; ready drops while a transfer is still pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_pend_ff    <= 1'b0;
      w_pend_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      aw_idx_ff     <= 16'h0000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end
    else
    begin
      aw_pend_ff    <= nxt_aw_pend;
      w_pend_ff     <= nxt_w_pend;
      s_axi_awready <= ~nxt_aw_pend & ~nxt_bvalid;
      s_axi_wready  <= ~nxt_w_pend & ~nxt_bvalid;
      s_axi_bvalid  <= nxt_bvalid;
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid  <= nxt_rvalid;
      if (aw_hs)
        aw_idx_ff <= s_axi_awaddr[ADDR_W-1:2];
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write)
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs)
      begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // software registers; reserved control bits are stored as written
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff   <= RESET_WORD;
      adcf_ff   <= RESET_WORD;
      pll_lo_ff <= RESET_WORD;
      pll_hi_ff <= 13'h0000;
      ccf_lo_ff <= RESET_WORD;
      ccf_hi_ff <= 11'h000;
      phscl_ff  <= RESET_WORD;
    end
    else
    begin
      // mono and de-emphasis fields feed the demodulator
      // bits 14 to 12 switch the filter inputs to external pins
      if (wr_ctrl) ctrl_ff   <= merge16(ctrl_ff, wdata_ff, wstrb_ff);
      if (wr_adcf) adcf_ff   <= merge16(adcf_ff, wdata_ff, wstrb_ff);
      if (wr_pllo) pll_lo_ff <= merge16(pll_lo_ff, wdata_ff, wstrb_ff);
      if (wr_plhi) pll_hi_ff <= plhi_word[12:0];
      if (wr_cclo) ccf_lo_ff <= merge16(ccf_lo_ff, wdata_ff, wstrb_ff);
      if (wr_cchi) ccf_hi_ff <= cchi_word[10:0];
      if (wr_phs)  phscl_ff  <= merge16(phscl_ff, wdata_ff, wstrb_ff);
    end
  end

  // tuning and divider values handed to the front end
  wire signed [26:0] ccf_word = {ccf_hi_ff, ccf_lo_ff};
  wire [5:0] nxt_vco_div = (vco_divider_select == 2'h0) ? VCO_DIV_36 :
                           (vco_divider_select == 2'h3) ? VCO_DIV_25 :
                           VCO_DIV_30;
  wire [4:0] nxt_ch_div  = (channel_divider_select == 2'h0) ? CH_DIV_16 :
                           (channel_divider_select == 2'h2) ? CH_DIV_20 :
                           CH_DIV_24;
  wire [7:0] whole_part  = {nxt_vco_div, 2'h0} + CCF_BASE;
  wire signed [29:0] nxt_vco_mult = $signed({1'b0, whole_part, 21'h00_0000})
                           + $signed({{3{ccf_word[26]}}, ccf_word});
  wire signed [26:0] nxt_tune = ctrl_ff.auto_fine_tune_enable ?
                           27'(ccf_word + fine_tune_offset) : ccf_word;

  // scaling treats 128 as unity gain, so 111 and 137 trim by about -13 % and +7 %
  wire signed [24:0] i_prod = i_in * $signed({1'b0, phscl_ff[15:8]});
  wire signed [24:0] q_prod = q_in * $signed({1'b0, phscl_ff[7:0]});

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_reset_ff   <= 1'b1;
      pilot_factor_ff <= 29'h0000_0000;
      tune_word_ff    <= 27'h000_0000;
      vco_div_ff      <= VCO_DIV_36;
      ch_div_ff       <= CH_DIV_16;
      vco_mult_ff     <= 30'h0000_0000;
      i_scaled_ff     <= 16'h0000;
      q_scaled_ff     <= 16'h0000;
    end
    else
    begin
      filt_reset_ff   <= ~ctrl_ff.global_sync_enable;
      pilot_factor_ff <= {pll_hi_ff, pll_lo_ff};
      tune_word_ff    <= nxt_tune;
      vco_div_ff      <= nxt_vco_div;
      ch_div_ff       <= nxt_ch_div;
      vco_mult_ff     <= nxt_vco_mult;
      i_scaled_ff     <= ctrl_ff.iq_scaling_enable ?
                         i_prod[IQ_SHIFT+15:IQ_SHIFT] : i_in;
      q_scaled_ff     <= ctrl_ff.iq_scaling_enable ?
                         q_prod[IQ_SHIFT+15:IQ_SHIFT] : q_in;
    end
  end

  // sample capture; nothing is taken while the filters sit in reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_ff  <= 18'h0_0000;
      right_ff <= 18'h0_0000;
    end
    else if (sample_strobe && ctrl_ff.global_sync_enable)
    begin
      left_ff  <= left_in;
      right_ff <= right_in;
    end
  end

  // bit clock nco; edges pull the phase only while alignment is free
  wire        rds_run  = ctrl_ff.radio_data_enable
                       & ctrl_ff.global_sync_enable;
  wire        rx_edge  = baseband_bit ^ bit_d_ff;
  wire        steer    = rx_edge & ~ctrl_ff.radio_data_hold_alignment;
  wire [31:0] nudge    = ~steer ? 32'h0000_0000 :
                         nco_ff[31] ? (32'h0000_0000 - NCO_NUDGE) : NCO_NUDGE;
  wire [32:0] nco_sum  = {1'b0, nco_ff} + {1'b0, NCO_INC};
  wire        bit_tick = rds_run & nco_sum[32];

  // block framing; a syndrome of zero after the offset marks a block
  wire [25:0] nxt_shift = {shift_ff[24:0], bit_d_ff};
  wire [9:0]  syn = nxt_shift[9:0] ^ crc10(nxt_shift[25:10]);
  wire        hit_a = syn == OFS_A;
  wire        hit_b = syn == OFS_B;
  wire        hit_c = (syn == OFS_C) | (syn == OFS_CP);
  wire        hit_d = syn == OFS_D;
  wire        any_hit = hit_a | hit_b | hit_c | hit_d;
  wire [1:0]  hit_idx = hit_b ? 2'h1 : hit_c ? 2'h2 : hit_d ? 2'h3 : 2'h0;
  wire        realign = any_hit & (~synced_ff
                      | ~ctrl_ff.radio_data_hold_alignment);
  wire        on_edge = synced_ff & (bitcnt_ff == BLOCK_LAST);
  wire [1:0]  seq_idx = blk_ff + 2'h1;
  wire        emit    = bit_tick & (realign | on_edge);
  wire [1:0]  out_idx = realign ? hit_idx : seq_idx;
  wire        out_ok  = realign | exp_match(syn, seq_idx);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rds_run)
    begin
      nco_ff    <= 32'h0000_0000;
      bit_d_ff  <= 1'b0;
      synced_ff <= 1'b0;
      bitcnt_ff <= 5'h00;
      blk_ff    <= 2'h0;
      shift_ff  <= 26'h000_0000;
    end
    else
    begin
      nco_ff   <= nco_sum[31:0] + nudge;
      bit_d_ff <= baseband_bit;
      if (bit_tick)
      begin
        shift_ff  <= nxt_shift;
        bitcnt_ff <= emit ? 5'h00 : bitcnt_ff + 5'h01;
        if (emit)
        begin
          synced_ff <= 1'b1;
          blk_ff    <= out_idx;
        end
      end
    end
  end

  // published block; data and check always change on the same edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rds_data_ff <= 16'h0000;
      radio_block_check_ff  <= 13'h0000;
      rds_irq_ff  <= 1'b0;
    end
    else
    begin
      rds_irq_ff <= emit;
      if (emit)
      begin
        rds_data_ff <= nxt_shift[25:10];
        radio_block_check_ff  <= {nxt_shift[9:0], out_ok, out_idx};
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_filt_reset_follow: assert property (
    ##1 filt_reset_ff == !$past(ctrl_ff.global_sync_enable))
    else $error("filter reset does not follow global enable");
  a_mode_fields_wired: assert property (
    !wr_ctrl |=> $stable(ctrl_ff))
    else $error("control word changed without a write");
  a_rds_idle_off: assert property (
    !rds_run |=> !rds_irq_ff)
    else $error("block request while decoding disabled");
  a_tune_fixed: assert property (
    !ctrl_ff.auto_fine_tune_enable |=> tune_word_ff == $past(ccf_word))
    else $error("tuning word moved with fine tune off");
  a_iq_bypass: assert property (
    !ctrl_ff.iq_scaling_enable |=> i_scaled_ff == $past(i_in))
    else $error("I path altered while scaling off");
  a_vco_table: assert property (
    vco_divider_select == 2'h3 |=> vco_div_ff == VCO_DIV_25)
    else $error("vco divider code 11 wrong");
  a_chan_table: assert property (
    channel_divider_select == 2'h1 |=> ch_div_ff == CH_DIV_24)
    else $error("channel divider code 01 wrong");
  a_block_pair: assert property (
    $changed(radio_block_check_ff) |-> rds_irq_ff)
    else $error("check word changed without block request");
  a_irq_pulse: assert property (
    rds_irq_ff |=> !rds_irq_ff)
    else $error("block request longer than one cycle");
  a_bresp_timing: assert property (
    do_write |=> s_axi_bvalid)
    else $error("write response missing after write");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");

  c_block_seen: cover property (rds_irq_ff && radio_block_check_ff[2]);
  c_write_read: cover property (do_write ##[1:20] s_axi_rvalid);
  c_sync_cycle: cover property (filt_reset_ff ##1 !filt_reset_ff);

endmodule
`default_nettype wire

// ==== test/fmr_fe_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fmr_fe_model
(
  input  wire logic               aclk,          // system clock
  input  wire logic               aresetn,       // sync reset, low
  input  wire logic               fire,          // bench asks a sample
  input  wire logic [17:0]        lval,          // left to deliver
  input  wire logic [17:0]        rval,          // right to deliver
  output logic                    sample_strobe, // one-cycle pulse
  output logic [17:0]             left_in,       // left sample
  output logic [17:0]             right_in,      // right sample
  output logic signed [15:0]      i_in,          // raw I level
  output logic signed [15:0]      q_in,          // raw Q level
  output logic                    baseband_bit   // sliced data level
);
  // samples valid only with the strobe; inverted otherwise so a
  // design that captures off-strobe sees garbage, not a stale value
  always_ff @(posedge aclk)
  begin
    sample_strobe <= aresetn & fire;
    left_in       <= fire ? lval : ~left_in;
    right_in      <= fire ? rval : ~right_in;
    i_in          <= 16'sh03e8;
    q_in          <= 16'sh03e8;
    baseband_bit  <= aresetn & ~baseband_bit;
  end
endmodule
`default_nettype wire

// ==== test/fmr_demod_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module fmr_demod_ctrl_tb;
  import fmr_pkg::*;
  logic                aclk = 0, aresetn = 0, fire = 0;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic                s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic                s_axi_bready = 0, s_axi_arvalid = 0;
  logic                s_axi_rready = 0;
  logic [31:0]         s_axi_wdata = '0, rd;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic [1:0]          vco_divider_select = 0, channel_divider_select = 0;
  logic [1:0]          rs;
  logic signed [26:0]  fine_tune_offset = '0;
  logic [17:0]         lval = '0, rval = '0;
  wire logic           s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic           s_axi_arready, s_axi_rvalid, sample_strobe;
  wire logic           baseband_bit, filt_reset_ff, rds_irq_ff;
  wire logic [1:0]     s_axi_bresp, s_axi_rresp;
  wire logic [31:0]    s_axi_rdata;
  wire logic [17:0]    left_in, right_in;
  wire logic signed [15:0] i_in, q_in, i_scaled_ff, q_scaled_ff;
  fmr_ctrl_t           ctrl_ff;
  wire logic [28:0]    pilot_factor_ff;
  wire logic signed [26:0] tune_word_ff;
  wire logic [5:0]     vco_div_ff;
  wire logic [4:0]     ch_div_ff;
  wire logic signed [29:0] vco_mult_ff;
  logic [5:0]          vt [4] = '{6'h24, 6'h1e, 6'h1e, 6'h19};
  logic [4:0]          ct [4] = '{5'h10, 5'h18, 5'h14, 5'h18};
  int                  n_errors = 0, total_checks = 0;

  fmr_demod_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .vco_divider_select,
    .channel_divider_select, .fine_tune_offset, .i_in, .q_in,
    .sample_strobe, .left_in, .right_in, .baseband_bit, .ctrl_ff,
    .filt_reset_ff, .pilot_factor_ff, .tune_word_ff, .vco_div_ff, .ch_div_ff,
    .vco_mult_ff, .i_scaled_ff, .q_scaled_ff, .rds_irq_ff);
  fmr_fe_model fe_u (.aclk, .aresetn, .fire, .lval, .rval, .sample_strobe,
    .left_in, .right_in, .i_in, .q_in, .baseband_bit);

  // 50 MHz
  always #10 aclk = ~aclk;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // bus master: addresses are four times the register index
  task wr(input logic [15:0] ix, input logic [15:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 64 && !s_axi_bvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    chk("write_answer", 32'h1, {31'h0, n < 64});
    if (n >= 64) test_done;
  endtask

  task rdr(input logic [15:0] ix);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 64 && !s_axi_rvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    chk("read_answer", 32'h1, {31'h0, n < 64});
    if (n >= 64) test_done;
  endtask

  task pulse(input logic [17:0] l, input logic [17:0] r);
    @(posedge aclk);
    lval <= l;
    rval <= r;
    fire <= 1;
    @(posedge aclk);
    fire <= 0;
  endtask

  task t_tune;
    rdr(IDX_DEMOD_CONTROL);
    chk("ctrl_reset", 32'h0, rd);
    chk("filt_reset", 32'h1, {31'h0, filt_reset_ff});
    wr(IDX_CARRIER_HIGH, 16'hff87);
    wr(IDX_CARRIER_LOW, 16'hffff);
    wr(IDX_PILOT_LOW, 16'haaaa);
    wr(IDX_PILOT_HIGH, 16'h032a);
    wr(IDX_ADC_FILTER_CFG, 16'h0004);
    wr(IDX_DEMOD_CONTROL, 16'h0041);
    rdr(IDX_ADC_FILTER_CFG);
    chk("adc_cfg", 32'h0000_0004, rd);
    rdr(IDX_CARRIER_HIGH);
    chk("ccf_high", 32'h0000_0787, rd);
    chk("tune", 32'h0787_ffff, {5'h0, tune_word_ff});
    chk("vco_mult", 32'h1387_ffff, {2'h0, vco_mult_ff});
    chk("pilot", 32'h032a_aaaa, {3'h0, pilot_factor_ff});
    chk("filt_run", 32'h0, {31'h0, filt_reset_ff});
    fine_tune_offset <= 27'sh000_0010;
    wr(IDX_DEMOD_CONTROL, 16'h0043);
    repeat (2) @(posedge aclk);
    chk("tune_auto", 32'h0788_000f, {5'h0, tune_word_ff});
    $display("tune test done");
  endtask

  task t_div;
    for (int i = 0; i < 4; i++)
    begin
      vco_divider_select <= 2'(i);
      channel_divider_select <= 2'(i);
      repeat (4) @(posedge aclk);
      chk("vco_div", {26'h0, vt[i]}, {26'h0, vco_div_ff});
      chk("ch_div", {27'h0, ct[i]}, {27'h0, ch_div_ff});
    end
    $display("divider test done");
  endtask

  task t_samp;
    pulse(18'h3_5a5b, 18'h0_0002);
    rdr(IDX_LEFT_HIGH);
    chk("left_high", 32'h0000_d696, rd);
    rdr(IDX_LEFT_LOW);
    chk("left_low", 32'h0000_c000, rd);
    rdr(IDX_RIGHT_LOW);
    chk("right_low", 32'h0000_8000, rd);
    wr(IDX_DEMOD_CONTROL, 16'h0001);
    pulse(18'h0_1111, 18'h0_1111);
    rdr(IDX_LEFT_HIGH);
    chk("held_left", 32'h0000_d696, rd);
    $display("sample test done");
  endtask

  task t_iq;
    wr(IDX_IQ_SCALE, 16'h8040);
    wr(IDX_DEMOD_CONTROL, 16'h00c1);
    repeat (4) @(posedge aclk);
    chk("i_scaled", 32'd1000, 32'(i_scaled_ff));
    chk("q_scaled", 32'd500, 32'(q_scaled_ff));
    $display("scaling test done");
  endtask

  task t_bus;
    rdr(16'hfe46);
    chk("unmapped_resp", {30'h0, RESP_DECERR}, {30'h0, rs});
    chk("unmapped_data", 32'h0, rd);
    wr(IDX_BLOCK_DATA, 16'h1234);
    chk("ro_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    rdr(IDX_BLOCK_DATA);
    chk("ro_data", 32'h0, rd);
    $display("bus test done");
  endtask

  task t_mode;
    wr(IDX_DEMOD_CONTROL, 16'h7018);
    @(posedge aclk);
    chk("mono", 32'h1, {31'h0, ctrl_ff.single_channel_select});
    chk("deemph", 32'h1, {31'h0, ctrl_ff.deemphasis_select});
    chk("ext_in", 32'h7, {29'h0, ctrl_ff[14:12]});
    chk("no_block", 32'h0, {31'h0, rds_irq_ff});
    $display("mode test done");
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_tune;
    t_div;
    t_samp;
    t_iq;
    t_bus;
    t_mode;
    test_done;
  end
endmodule
`default_nettype wire
